// ### acfg_channel_regs.v
// APB register bank for four channel gain, enable, bias and data pin use
`timescale 1ns/100ps
`include "acfg_regs.vh"

module acfg_channel_regs #(
  parameter CHANNELS = 4
) (
  // Clock and reset
  input  wire                    clk,
  input  wire                    rstn,
  // APB slave
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [9:0]              paddr,
  input  wire [31:0]             pwdata,
  input  wire [3:0]              pstrb,
  output wire                    pready,
  output reg  [31:0]             prdata,
  output wire                    pslverr,
  // Channel controls
  output wire [2*CHANNELS-1:0]   amp_level,
  output wire [6*CHANNELS-1:0]   amp_gain_db,
  output wire [CHANNELS-1:0]     power_on_bits,
  output wire [CHANNELS-1:0]     ch_out_oe,
  output wire                    bias_gen_on,
  // Serial data output pin
  input  wire                    sdo_serial,
  input  wire                    sdo_serial_oe,
  input  wire                    sdo_in,
  output wire                    sdo_out,
  output wire                    sdo_oe
);

  reg  [7:0] channel_gain_select;
  reg  [7:0] channel_enable;
  reg  [7:0] bias_keep_alive;
  reg  [7:0] pin_output_control;
  reg        pin_input_sense;
  reg  [2:0] sdo_sync;
  wire [7:0] word_idx;
  wire       wr_acc;
  wire       rd_acc;
  wire       lane0;
  wire       pin_mode;

  // Map a two-bit gain code to amplifier gain in dB
  function [5:0] gain_db;
    input [1:0] code;
    begin
      case (code)
        2'h0:    gain_db = `ACFG_GAIN_DB_0;
        2'h1:    gain_db = `ACFG_GAIN_DB_1;
        2'h2:    gain_db = `ACFG_GAIN_DB_2;
        default: gain_db = `ACFG_GAIN_DB_3;
      endcase
    end
  endfunction

  // Bus decode; every access completes with no wait state
  assign word_idx = paddr[9:2];
  assign wr_acc   = psel & penable & pwrite;
  assign rd_acc   = psel & ~penable & ~pwrite;
  assign lane0    = pstrb[0];
  assign pready   = 1'b1;
  assign pslverr  = 1'b0;

  // Register writes; unused bits masked off
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      channel_gain_select <= `ACFG_GAIN_RST;
      channel_enable      <= `ACFG_ENABLE_RST;
      bias_keep_alive     <= `ACFG_BIAS_RST;
      pin_output_control  <= `ACFG_PIN_OUT_RST;
    end
    else if (wr_acc && lane0)
    begin
      if (word_idx == `ACFG_IDX_GAIN)
        channel_gain_select <= pwdata[7:0];
      else if (word_idx == `ACFG_IDX_ENABLE)
        channel_enable <= pwdata[7:0] & `ACFG_ENABLE_MASK;
      else if (word_idx == `ACFG_IDX_BIAS)
        bias_keep_alive <= pwdata[7:0] & `ACFG_BIAS_MASK;
      else if (word_idx == `ACFG_IDX_PIN_OUT)
        pin_output_control <= pwdata[7:0] & `ACFG_PIN_OUT_MASK;
    end
  end

  // Pin level synchroniser; with pin mode off, change taken once stages two and three agree
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sdo_sync        <= 3'h0;
      pin_input_sense <= `ACFG_SENSE_RST;
    end
    else
    begin
      sdo_sync <= {sdo_sync[1:0], sdo_in};
      if (!pin_mode && (sdo_sync[1] == sdo_sync[2]))
        pin_input_sense <= sdo_sync[2];
    end
  end

  // Read data registered in setup phase; unmapped reads give zero
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      prdata <= 32'h0;
    else if (rd_acc)
    begin
      if (word_idx == `ACFG_IDX_GAIN)
        prdata <= {24'h0, channel_gain_select};
      else if (word_idx == `ACFG_IDX_ENABLE)
        prdata <= {24'h0, channel_enable};
      else if (word_idx == `ACFG_IDX_BIAS)
        prdata <= {24'h0, bias_keep_alive};
      else if (word_idx == `ACFG_IDX_PIN_OUT)
        prdata <= {24'h0, pin_output_control};
      else if (word_idx == `ACFG_IDX_PIN_SENSE)
        prdata <= {31'h0, pin_input_sense};
      else
        prdata <= 32'h0;
    end
  end

  // Per channel controls
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1)
    begin : g_ch
      assign amp_level[2*g+1:2*g] =
        channel_gain_select[`ACFG_GAIN_W*g+1:`ACFG_GAIN_W*g];
      assign amp_gain_db[6*g+5:6*g] =
        gain_db(channel_gain_select[2*g+1:2*g]);
    end
  endgenerate

  assign power_on_bits = channel_enable[CHANNELS-1:0];
  assign ch_out_oe     = channel_enable[CHANNELS-1:0];

  // Bias on with any channel, or held on by keep-alive
  assign bias_gen_on = (|channel_enable[CHANNELS-1:0])
                     | bias_keep_alive[0];

  // Data pin: register drives it in pin mode, else serial port
  assign pin_mode = pin_output_control[`ACFG_PIN_MODE_BIT];
  assign sdo_out  = pin_mode ?
                    pin_output_control[`ACFG_PIN_DATA_BIT]
                    : sdo_serial;
  assign sdo_oe   = pin_mode | sdo_serial_oe;

endmodule // acfg_channel_regs

// ### acfg_channel_regs_tb.sv
// Self-checking bench for the channel configuration bank
`timescale 1ns/100ps
module acfg_channel_regs_tb;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, ext, pin;
  logic bias_gen_on, sdo_out, sdo_oe;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] rd, amp_level;
  logic [3:0] power_on_bits, ch_out_oe;
  logic [23:0] amp_gain_db;
  logic [9:0] ad[5] = '{10'h54, 10'h5c, 10'h60, 10'h74, 10'h78};
  int error_cnt, cmp_count, cyc;
  acfg_channel_regs acfg_channel_regs_i (.*, .pstrb(4'hf),
    .sdo_serial(1'h0), .sdo_serial_oe(1'h0), .sdo_in(pin));
  acfg_pin acfg_pin_i (.oe(sdo_oe), .drv(sdo_out), .ext(ext), .pin(pin));
  // Clock and time-zero inputs
  initial
  begin
    {clk, rstn, psel, penable, pwrite, ext} = 6'h0;
    paddr = 10'h0;
    pwdata = 32'h0;
    forever #50 clk = ~clk;
  end
  // Cycle ceiling
  always @(posedge clk)
    if (++cyc > 3000)
    begin
      error_cnt++;
      stop_test;
    end
  task stop_test;
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata[7:0];
    psel <= 1'h0;
    penable <= 1'h0;
    @(negedge clk);
  endtask
  task t_reset;
    foreach (ad[i])
    begin
      apb(1'h0, ad[i], 8'h0);
      chk(rd, 8'h0);
    end
    apb(1'h0, 10'h58, 8'h0);
    chk(rd, 8'h0);
  endtask
  task t_regs;
    apb(1'h1, 10'h54, 8'he4);
    chk(amp_gain_db, {6'h24, 6'h1e, 6'h18, 6'h12});
    apb(1'h1, 10'h5c, 8'h0f);
    chk(bias_gen_on, 1'h1);
    apb(1'h1, 10'h5c, 8'hf2);
    apb(1'h0, 10'h5c, 8'h0);
    chk(rd, 8'h02);
    chk(ch_out_oe, 4'h2);
    apb(1'h1, 10'h5c, 8'h0);
    chk(bias_gen_on, 1'h0);
    apb(1'h1, 10'h60, 8'h1);
    chk(bias_gen_on, 1'h1);
  endtask
  task t_rerst;
    apb(1'h1, 10'h5c, 8'h0f);
    @(posedge clk);
    rstn <= 1'h0;
    @(posedge clk);
    rstn <= 1'h1;
    @(negedge clk);
    chk(power_on_bits, 4'h0);
    chk(bias_gen_on, 1'h0);
  endtask
  task t_pin;
    @(posedge clk);
    ext <= 1'h1;
    repeat (3) @(posedge clk);
    apb(1'h0, 10'h78, 8'h0);
    chk(rd, 8'h1);
    apb(1'h1, 10'h74, 8'h1);
    chk({sdo_oe, pin}, 2'h2);
    apb(1'h1, 10'h78, 8'hfe);
    apb(1'h0, 10'h78, 8'h0);
    chk(rd, 8'h1);
    apb(1'h1, 10'h74, 8'h3);
    chk(sdo_out, 1'h1);
    apb(1'h1, 10'h74, 8'h0);
    chk(sdo_oe, 1'h0);
  endtask
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    t_reset;
    t_regs;
    t_rerst;
    t_pin;
    stop_test;
  end
endmodule // acfg_channel_regs_tb

// ### acfg_chk.sv
// Checker for the channel configuration bank
`timescale 1ns/100ps
module acfg_chk (
  input logic clk, rstn, psel, penable, pwrite, bias_gen_on,
  input logic sdo_out, sdo_oe,
  input logic [9:0] paddr,
  input logic [31:0] pwdata, prdata,
  input logic [3:0] pstrb, power_on_bits, ch_out_oe,
  input logic [7:0] amp_level,
  input logic [23:0] amp_gain_db
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Write strobe and index
  logic wr;
  logic [7:0] ix;
  assign wr = psel & penable & pwrite & pstrb[0];
  assign ix = paddr[9:2];
  a_gain_map: assert property (
    amp_gain_db[23:18] == 6'h12 + 6'h6 * amp_level[7:6]) else $error("gain");
  a_gain_wr: assert property (
    wr && ix == 8'h15 |=> amp_level == $past(pwdata[7:0])) else $error("gw");
  a_en_wr: assert property (
    wr && ix == 8'h17 |=> power_on_bits == $past(pwdata[3:0]))
    else $error("en");
  a_en_rst: assert property (
    $rose(rstn) |-> power_on_bits == 4'h0) else $error("rst");
  a_oe_hiz: assert property (
    ch_out_oe == power_on_bits) else $error("oe");
  a_bias_auto: assert property (
    |power_on_bits |-> bias_gen_on) else $error("bias");
  a_bias_keep: assert property (
    wr && ix == 8'h18 && pwdata[0] |=> bias_gen_on) else $error("keep");
  a_pin_drive: assert property (
    wr && ix == 8'h1d && pwdata[0] |=> sdo_oe && sdo_out == $past(pwdata[1]))
    else $error("pin");
  a_unmapped: assert property (
    psel && penable && !pwrite && ix == 8'h16 |-> prdata == 32'h0)
    else $error("unmapped");
endmodule // acfg_chk
bind acfg_channel_regs acfg_chk acfg_chk_i (.*);

// ### acfg_pin.sv
// Pin model: data pin level from device or host
`timescale 1ns/100ps
module acfg_pin (
  // Drive and pin
  input  wire oe, drv, ext,
  output wire pin
);
  // Device drive wins, else host level
  assign pin = oe ? drv : ext;
endmodule // acfg_pin

// ### acfg_regs.vh
// Register map and field constants for the channel configuration bank
// Operation
// - Gain codes 00..11 give 18 to 36 dB
// - Gain fields D,C,B,A at bits 7..0
// - Enable bit n powers channel A to D
// - Channel enables clear to zero at power-on
// - Disabled channel outputs go high-impedance
// - Any enabled channel turns bias generator on
// - Keep-alive bit holds bias generator on
// - Pin mode bit takes data pin as output
// - Pin mode drives write data bit onto pin
// - Sense bit reports pin level when mode off
`ifndef ACFG_REGS_VH
`define ACFG_REGS_VH

// Printed offsets are register indices; byte address is four times
`define ACFG_IDX_GAIN       8'h15
`define ACFG_IDX_ENABLE     8'h17
`define ACFG_IDX_BIAS       8'h18
`define ACFG_IDX_PIN_OUT    8'h1d
`define ACFG_IDX_PIN_SENSE  8'h1e

// Field layout
`define ACFG_GAIN_W         2
`define ACFG_ENABLE_MASK    8'h0f
`define ACFG_BIAS_MASK      8'h01
`define ACFG_PIN_OUT_MASK   8'h03
`define ACFG_PIN_MODE_BIT   0
`define ACFG_PIN_DATA_BIT   1
`define ACFG_SENSE_BIT      0

// Reset values
`define ACFG_GAIN_RST       8'h00
`define ACFG_ENABLE_RST     8'h00
`define ACFG_BIAS_RST       8'h00
`define ACFG_PIN_OUT_RST    8'h00
`define ACFG_SENSE_RST      1'b0

// Gain in dB for each code
`define ACFG_GAIN_DB_0      6'd18
`define ACFG_GAIN_DB_1      6'd24
`define ACFG_GAIN_DB_2      6'd30
`define ACFG_GAIN_DB_3      6'd36

`endif
